// ===== verilog/rtcev_core.sv
// Calendar alarm match, sticky event flags and interrupt mask with an Avalon-MM register slave.
// Notes on behaviour
// - Month alarm value is stored and compared with the month counter when enabled.
// - Bit 23 enables month matching; zero disables it.
// - Date alarm value is stored and compared with the date counter when enabled.
// - Bit 31 enables date matching; zero disables it.
// - Status bit 0 reports that time or calendar may be updated.
// - Status bit 1 sets when an enabled alarm match occurs.
// - Status bit 2 is sticky, set by any second event.
// - Status bit 3 is sticky, set by the selected time event.
// - Status bit 4 is sticky, set by the selected calendar event.
// - Writing one to the clear register clears flags; zero leaves them.
// - Writing one to the enable register sets mask bits; zero does nothing.
// - Writing one to the disable register clears mask bits; zero does nothing.
// - Mask register reads one for each enabled interrupt source.
// - Time event is minute change, hour change, noon or midnight.
// - Calendar event is week, month or year change.
// - Time select codes: 00 minute, 01 hour, 10 midnight, 11 noon.
// - Calendar codes: 00 week, 01 month, 10 year, 11 none; all at 00:00:00.
// - Stop requests halt counting; counters are programmable after acknowledge.
//
// Design decision made here: the Avalon-MM slave port.
`default_nettype none
module rtcev_core (
  input  wire logic        core_clk_in,        // Peripheral clock, 20 MHz.
  input  wire logic        rst_in,             // Asynchronous reset, active high.
  input  wire logic        clk_en_in,          // Freezes all state while low.
  input  wire logic [7:0]  avs_address_in,     // Byte address.
  input  wire logic        avs_read_in,        // Read request.
  input  wire logic        avs_write_in,       // Write request.
  input  wire logic [31:0] avs_writedata_in,   // Write data.
  input  wire logic [3:0]  avs_byteenable_in,  // Byte enables.
  output logic      [31:0] avs_readdata_out,   // Read data, registered.
  output logic             avs_waitrequest_out,// Stall, low when answered.
  input  wire logic [4:0]  month_bcd_in,       // Month counter, BCD.
  input  wire logic [5:0]  date_bcd_in,        // Date counter, BCD.
  input  wire logic        time_alarm_hit_in,  // Time alarm comparator match.
  input  wire logic        second_tick_in,     // One pulse per second change.
  input  wire logic        minute_tick_in,     // Minute change pulse.
  input  wire logic        hour_tick_in,       // Hour change pulse.
  input  wire logic        noon_tick_in,       // Noon pulse.
  input  wire logic        midnight_tick_in,   // Midnight pulse.
  input  wire logic        week_tick_in,       // Monday 00:00:00 pulse.
  input  wire logic        month_tick_in,      // First of month 00:00:00 pulse.
  input  wire logic        year_tick_in,       // January 1st 00:00:00 pulse.
  input  wire logic        time_stopped_in,    // Time counters have halted.
  input  wire logic        cal_stopped_in,     // Calendar counters have halted.
  output logic             stop_time_request_out,     // Halt time counting.
  output logic             stop_calendar_request_out, // Halt calendar counting.
  output logic      [1:0]  time_event_select_out,     // Time event choice.
  output logic             irq_out             // Level interrupt.
);

  // -----------------------------------------------------------------
  // Register state
  // -----------------------------------------------------------------
  logic [31:0] calendar_alarm;
  logic [31:0] event_ctrl;
  logic [4:0]  event_flags;
  logic [4:0]  irq_mask;
  logic        answered;
  logic        alarm_prev;

  // -----------------------------------------------------------------
  // Helper functions
  // -----------------------------------------------------------------
  // Byte-lane merge used by every read-write register.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  // -----------------------------------------------------------------
  // Bus access decode
  // -----------------------------------------------------------------
  // Every access seen while clk_en_in is high is answered one cycle later, so waitrequest is high only in the first cycle.
  logic access;
  logic wr_go;
  logic [4:0] wr_low;
  assign access              = (avs_read_in | avs_write_in) & ~answered;
  assign avs_waitrequest_out = access;
  assign wr_go               = avs_write_in & access & clk_en_in;
  assign wr_low              = avs_byteenable_in[0] ? avs_writedata_in[4:0] : 5'h00;

  // Answer toggle: one stall cycle, then the request completes.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      answered <= 1'b0;
    else if (clk_en_in)
      answered <= access;
  end

  // -----------------------------------------------------------------
  // Read-write registers
  // -----------------------------------------------------------------
  // Calendar alarm fields with their enables; reserved bits are kept at zero.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      calendar_alarm <= rtcev_pkg::CAL_ALARM_RESET;
    else if (wr_go && avs_address_in == rtcev_pkg::OFS_CAL_ALARM)
      calendar_alarm <= merge_bytes(calendar_alarm, avs_writedata_in, avs_byteenable_in)
                        & 32'hBF9F_0000;
  end

  // Control bits steering event selection and stop requests.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      event_ctrl <= rtcev_pkg::CTRL_RESET;
    else if (wr_go && avs_address_in == rtcev_pkg::OFS_EVENT_CTRL)
      event_ctrl <= merge_bytes(event_ctrl, avs_writedata_in, avs_byteenable_in) & 32'h0003_0303;
  end

  logic [1:0] tsel;
  logic [1:0] csel;
  assign tsel                      = event_ctrl[rtcev_pkg::CTRL_TSEL_LSB +: 2];
  assign csel                      = event_ctrl[rtcev_pkg::CTRL_CSEL_LSB +: 2];
  assign stop_time_request_out     = event_ctrl[rtcev_pkg::CTRL_STOP_TIME];
  assign stop_calendar_request_out = event_ctrl[rtcev_pkg::CTRL_STOP_CAL];
  assign time_event_select_out     = tsel;

  // -----------------------------------------------------------------
  // Alarm match and event selection
  // -----------------------------------------------------------------
  // A disabled field always counts as matching; with neither enabled no alarm fires from the calendar side.
  logic month_on;
  logic date_on;
  logic month_ok;
  logic date_ok;
  logic cal_match;
  logic alarm_now;
  assign month_on  = calendar_alarm[rtcev_pkg::MONTH_ON_BIT];
  assign date_on   = calendar_alarm[rtcev_pkg::DATE_ON_BIT];
  assign month_ok  = ~month_on |
                     (calendar_alarm[rtcev_pkg::MONTH_LSB +: rtcev_pkg::MONTH_W] == month_bcd_in);
  assign date_ok   = ~date_on |
                     (calendar_alarm[rtcev_pkg::DATE_LSB +: rtcev_pkg::DATE_W] == date_bcd_in);
  assign cal_match = (month_on | date_on) & month_ok & date_ok;
  // The time alarm comparator ANDs in when calendar fields are enabled, and stands alone otherwise.
  assign alarm_now = (month_on | date_on) ? (cal_match & time_alarm_hit_in) : time_alarm_hit_in;

  logic time_ev;
  logic cal_ev;
  // Time event multiplexer.
  always_comb
  begin
    if (tsel == rtcev_pkg::TSEL_MINUTE)
      time_ev = minute_tick_in;
    else if (tsel == rtcev_pkg::TSEL_HOUR)
      time_ev = hour_tick_in;
    else if (tsel == rtcev_pkg::TSEL_MIDNIGHT)
      time_ev = midnight_tick_in;
    else
      time_ev = noon_tick_in;
  end

  // Calendar event multiplexer; the reserved code selects nothing.
  always_comb
  begin
    if (csel == rtcev_pkg::CSEL_WEEK)
      cal_ev = week_tick_in;
    else if (csel == rtcev_pkg::CSEL_MONTH)
      cal_ev = month_tick_in;
    else if (csel == rtcev_pkg::CSEL_YEAR)
      cal_ev = year_tick_in;
    else
      cal_ev = 1'b0;
  end

  // Alarm is flagged on the rising edge of the match so a long match sets the flag once.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      alarm_prev <= 1'b0;
    else if (clk_en_in)
      alarm_prev <= alarm_now;
  end

  // -----------------------------------------------------------------
  // Sticky flags
  // -----------------------------------------------------------------
  // Set beats clear in the same cycle so no event is lost to a racing clear.
  logic [4:0] set_vec;
  logic [4:0] clr_vec;
  assign set_vec[rtcev_pkg::FLAG_ACK]   = (stop_time_request_out & time_stopped_in) |
                                          (stop_calendar_request_out & cal_stopped_in);
  assign set_vec[rtcev_pkg::FLAG_ALARM] = alarm_now & ~alarm_prev;
  assign set_vec[rtcev_pkg::FLAG_SEC]   = second_tick_in;
  assign set_vec[rtcev_pkg::FLAG_TIME]  = time_ev;
  assign set_vec[rtcev_pkg::FLAG_CAL]   = cal_ev;
  assign clr_vec = (wr_go && avs_address_in == rtcev_pkg::OFS_FLAG_CLEAR) ? wr_low : 5'h00;

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      event_flags <= rtcev_pkg::FLAGS_RESET;
    else if (clk_en_in)
      event_flags <= (event_flags & ~clr_vec) | set_vec;
  end

  // -----------------------------------------------------------------
  // Interrupt mask
  // -----------------------------------------------------------------
  // Set and clear ports; a simultaneous set is impossible since only one address is written per cycle.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      irq_mask <= rtcev_pkg::FLAGS_RESET;
    else if (wr_go && avs_address_in == rtcev_pkg::OFS_IRQ_SET)
      irq_mask <= irq_mask | wr_low;
    else if (wr_go && avs_address_in == rtcev_pkg::OFS_IRQ_CLEAR)
      irq_mask <= irq_mask & ~wr_low;
  end

  // Registered interrupt so the output is glitch free; it lags the flags by one cycle.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      irq_out <= 1'b0;
    else if (clk_en_in)
      irq_out <= |(event_flags & irq_mask);
  end

  // -----------------------------------------------------------------
  // Read data
  // -----------------------------------------------------------------
  // Write-only and unmapped offsets read as zero.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      avs_readdata_out <= rtcev_pkg::UNMAPPED_READ;
    else if (clk_en_in && avs_read_in && access)
    begin
      if (avs_address_in == rtcev_pkg::OFS_CAL_ALARM)
        avs_readdata_out <= calendar_alarm;
      else if (avs_address_in == rtcev_pkg::OFS_EVENT_FLAGS)
        avs_readdata_out <= {27'h0, event_flags};
      else if (avs_address_in == rtcev_pkg::OFS_IRQ_STATE)
        avs_readdata_out <= {27'h0, irq_mask};
      else if (avs_address_in == rtcev_pkg::OFS_EVENT_CTRL)
        avs_readdata_out <= event_ctrl;
      else
        avs_readdata_out <= rtcev_pkg::UNMAPPED_READ;
    end
  end

endmodule
`default_nettype wire

// ===== verilog/rtcev_pkg.sv
// Package of register offsets, field positions and encodings for the calendar alarm and event flag block.
`default_nettype none
package rtcev_pkg;
  // -----------------------------------------------------------------
  // Register byte offsets
  // -----------------------------------------------------------------
  localparam logic [7:0] OFS_CAL_ALARM    = 8'h14;
  localparam logic [7:0] OFS_EVENT_FLAGS  = 8'h18;
  localparam logic [7:0] OFS_FLAG_CLEAR   = 8'h1C;
  localparam logic [7:0] OFS_IRQ_SET      = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLEAR    = 8'h24;
  localparam logic [7:0] OFS_IRQ_STATE    = 8'h28;
  localparam logic [7:0] OFS_EVENT_CTRL   = 8'h30;
  // -----------------------------------------------------------------
  // Field positions
  // -----------------------------------------------------------------
  localparam int DATE_ON_BIT     = 31;
  localparam int DATE_LSB        = 24;
  localparam int DATE_W          = 6;
  localparam int MONTH_ON_BIT    = 23;
  localparam int MONTH_LSB       = 16;
  localparam int MONTH_W         = 5;
  localparam int FLAG_ACK        = 0;
  localparam int FLAG_ALARM      = 1;
  localparam int FLAG_SEC        = 2;
  localparam int FLAG_TIME       = 3;
  localparam int FLAG_CAL        = 4;
  localparam int NFLAGS          = 5;
  localparam int CTRL_STOP_TIME  = 0;
  localparam int CTRL_STOP_CAL   = 1;
  localparam int CTRL_TSEL_LSB   = 8;
  localparam int CTRL_CSEL_LSB   = 16;
  // -----------------------------------------------------------------
  // Reset values and event selection codes
  // -----------------------------------------------------------------
  localparam logic [31:0] CAL_ALARM_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam logic [4:0]  FLAGS_RESET     = 5'h00;
  localparam logic [1:0]  TSEL_MINUTE     = 2'h0;
  localparam logic [1:0]  TSEL_HOUR       = 2'h1;
  localparam logic [1:0]  TSEL_MIDNIGHT   = 2'h2;
  localparam logic [1:0]  TSEL_NOON       = 2'h3;
  localparam logic [1:0]  CSEL_WEEK       = 2'h0;
  localparam logic [1:0]  CSEL_MONTH      = 2'h1;
  localparam logic [1:0]  CSEL_YEAR       = 2'h2;
  localparam logic [31:0] UNMAPPED_READ   = 32'h0000_0000;
endpackage
`default_nettype wire

// ===== bench/rtcev_core_assertions.sv
// Checker of bus timing, control outputs and interrupt masking for the event flag block.
`default_nettype none
module rtcev_core_chk (
  input wire logic        core_clk_in,               // Clock.
  input wire logic        rst_in,                    // Reset.
  input wire logic        clk_en_in,                 // Run enable.
  input wire logic [7:0]  avs_address_in,            // Address.
  input wire logic        avs_read_in,               // Read.
  input wire logic        avs_write_in,              // Write.
  input wire logic [31:0] avs_writedata_in,          // Write data.
  input wire logic [3:0]  avs_byteenable_in,         // Byte enables.
  input wire logic [31:0] avs_readdata_out,          // Read data.
  input wire logic        avs_waitrequest_out,       // Stall.
  input wire logic        second_tick_in,            // Second pulse.
  input wire logic        stop_time_request_out,     // Stop time.
  input wire logic        stop_calendar_request_out, // Stop calendar.
  input wire logic [1:0]  time_event_select_out,     // Time select.
  input wire logic        irq_out                    // Interrupt.
);
  logic [4:0] mask_m;
  logic       wr_first;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // -----------------------------------------------------------------
  // Mask mirror
  // -----------------------------------------------------------------
  // The mask is rebuilt from bus writes, so the interrupt can be judged without internal state.
  assign wr_first = avs_write_in && avs_waitrequest_out && clk_en_in && avs_byteenable_in[0];
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      mask_m <= 5'h00;
    else if (wr_first && avs_address_in == rtcev_pkg::OFS_IRQ_SET)
      mask_m <= mask_m | avs_writedata_in[4:0];
    else if (wr_first && avs_address_in == rtcev_pkg::OFS_IRQ_CLEAR)
      mask_m <= mask_m & ~avs_writedata_in[4:0];
  end
  // -----------------------------------------------------------------
  // Properties
  // -----------------------------------------------------------------
  a_wait_first: assert property ($rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out)
    else $error("request not stalled in its first cycle");
  a_wait_done: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out && clk_en_in
    |=> !avs_waitrequest_out) else $error("request not answered in its second cycle");
  a_unmapped_read: assert property (avs_read_in && avs_waitrequest_out && avs_address_in == 8'h2C
    |=> avs_readdata_out == rtcev_pkg::UNMAPPED_READ) else $error("unmapped read not zero");
  a_ctrl_write: assert property (wr_first && avs_byteenable_in[1] &&
    avs_address_in == rtcev_pkg::OFS_EVENT_CTRL
    |=> {time_event_select_out, stop_calendar_request_out, stop_time_request_out} ==
    {$past(avs_writedata_in[9:8]), $past(avs_writedata_in[1:0])}) else $error("control outputs wrong");
  a_mask_read: assert property (avs_read_in && avs_waitrequest_out &&
    avs_address_in == rtcev_pkg::OFS_IRQ_STATE
    |=> avs_readdata_out == {27'h0, mask_m}) else $error("mask read wrong");
  a_irq_masked: assert property (mask_m == 5'h00 |=> !irq_out) else $error("interrupt with empty mask");
  a_irq_second: assert property (second_tick_in && clk_en_in &&
    mask_m[rtcev_pkg::FLAG_SEC] |=> ##1 irq_out) else $error("second event did not interrupt");
  a_rst_quiet: assert property ($fell(rst_in) |-> !irq_out &&
    !stop_time_request_out && !stop_calendar_request_out) else $error("outputs not idle after reset");
endmodule
bind rtcev_core rtcev_core_chk u_chk (.core_clk_in, .rst_in, .clk_en_in, .avs_address_in, .avs_read_in,
  .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .second_tick_in,
  .stop_time_request_out, .stop_calendar_request_out, .time_event_select_out, .irq_out);
`default_nettype wire

// ===== bench/rtc_calendar_alarm_status_irq_tb.sv
// Self-checking bench for the calendar alarm, event flags and interrupt mask block.
`default_nettype none
module rtc_calendar_alarm_status_irq_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [4:0]  month = 5'h11;
  logic [5:0]  date = 6'h15;
  logic [8:0]  ev = 9'h000;
  logic [1:0]  stopped = 2'h0;
  logic [31:0] rdata;
  logic        wait_req;
  logic        stop_t;
  logic        stop_c;
  logic [1:0]  tsel;
  logic        irq;
  logic [31:0] q;
  logic [31:0] car_tab [4] = '{32'h9592_0000, 32'h9592_0000, 32'h1512_0000, 32'h9612_0000};
  logic [4:0]  mon_tab [4] = '{5'h11, 5'h12, 5'h11, 5'h12};
  logic        alm_tab [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  int          err_total = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          k;
  // Event pulses: 0 second, 1..4 time codes in order, 5..7 calendar codes in order, 8 time alarm.
  rtcev_core DUT (
    .core_clk_in(clk), .rst_in(rst), .clk_en_in(1'b1), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req), .month_bcd_in(month), .date_bcd_in(date),
    .time_alarm_hit_in(ev[8]), .second_tick_in(ev[0]), .minute_tick_in(ev[1]), .hour_tick_in(ev[2]),
    .midnight_tick_in(ev[3]), .noon_tick_in(ev[4]), .week_tick_in(ev[5]), .month_tick_in(ev[6]),
    .year_tick_in(ev[7]), .time_stopped_in(stopped[0]), .cal_stopped_in(stopped[1]),
    .stop_time_request_out(stop_t), .stop_calendar_request_out(stop_c), .time_event_select_out(tsel),
    .irq_out(irq)
  );
  // -----------------------------------------------------------------
  // Clock, timeout and helpers
  // -----------------------------------------------------------------
  initial
  begin
    forever #25 clk = ~clk;
  end
  // The whole run needs well under a thousand cycles; a stuck handshake ends here.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // The request stands until waitrequest is sampled low at a rising edge, and read data is taken at that same edge.
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !we;
    wr <= we;
    addr <= a;
    wd <= d;
    do @(posedge clk); while (wait_req !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(nm, q, e);
  endtask
  task automatic pulse(input logic [8:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 9'h000;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // -----------------------------------------------------------------
  // Tests
  // -----------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdc("alarm reg", 8'h14, 32'h0);
    rdc("mask reset", 8'h28, 32'h0);
    rdc("unmapped", 8'h2C, 32'h0);
    xfer(1'b1, 8'h18, 32'h1F);
    rdc("flags ro", 8'h18, 32'h0);
    $display("test reset done");
    // Month and date matching, each field on and off, against a time alarm hit.
    for (k = 0; k < 4; k++)
    begin
      xfer(1'b1, 8'h14, car_tab[k]);
      rdc("alarm reg", 8'h14, car_tab[k]);
      month <= mon_tab[k];
      pulse(9'h100);
      rdc("alarm flag", 8'h18, {30'h0, alm_tab[k], 1'b0});
      xfer(1'b1, 8'h1C, 32'h1F);
    end
    $display("test alarm done");
    pulse(9'h001);
    pulse(9'h001);
    xfer(1'b1, 8'h1C, 32'h1B);
    rdc("second flag", 8'h18, 32'h04);
    xfer(1'b1, 8'h1C, 32'h04);
    rdc("second clear", 8'h18, 32'h0);
    $display("test sticky done");
    // Every selection code: an unselected event first, then the selected one.
    for (k = 0; k < 4; k++)
    begin
      xfer(1'b1, 8'h30, {14'h0, k[1:0], 6'h0, k[1:0], 8'h0});
      chk("time select", {30'h0, tsel}, 32'(k));
      pulse(9'(1 << (1 + (k + 1) % 4)) | (k == 3 ? 9'h0E0 : 9'(1 << (5 + (k + 1) % 3))));
      rdc("other events", 8'h18, 32'h0);
      pulse(9'(1 << (1 + k)) | (k == 3 ? 9'h000 : 9'(1 << (5 + k))));
      rdc("chosen events", 8'h18, {27'h0, k != 3, 4'h8});
      xfer(1'b1, 8'h1C, 32'h18);
    end
    $display("test events done");
    xfer(1'b1, 8'h30, 32'h3);
    chk("stop requests", {30'h0, stop_c, stop_t}, 32'h3);
    rdc("no ack", 8'h18, 32'h0);
    stopped <= 2'h3;
    rdc("ack", 8'h18, 32'h1);
    stopped <= 2'h0;
    xfer(1'b1, 8'h30, 32'h0);
    xfer(1'b1, 8'h1C, 32'h01);
    rdc("ack clear", 8'h18, 32'h0);
    $display("test ack done");
    xfer(1'b1, 8'h20, 32'h04);
    xfer(1'b1, 8'h20, 32'h0);
    xfer(1'b1, 8'h24, 32'h0);
    rdc("mask set", 8'h28, 32'h04);
    pulse(9'h001);
    repeat (2) @(negedge clk);
    chk("irq on", {31'h0, irq}, 32'h1);
    xfer(1'b1, 8'h24, 32'h04);
    rdc("mask off", 8'h28, 32'h0);
    @(negedge clk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    xfer(1'b1, 8'h20, 32'h1F);
    xfer(1'b1, 8'h24, 32'h1B);
    rdc("mask bits", 8'h28, 32'h04);
    xfer(1'b1, 8'h1C, 32'h04);
    @(negedge clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    $display("test irq done");
    wrap_up();
  end
endmodule
`default_nettype wire
